// ==== bix_pkg.sv ====
/*
 * Shared constants and carrier types for the small accumulator-core
 * execution block: register map, field positions, reset values, opcodes.
 * Assumes a single 250 MHz clock and a classic Wishbone register bus.
 */
package bix_pkg;

    // ==========================================================
    // Bus and datapath widths
    // ==========================================================
    localparam int ADR_W = 8;
    localparam int PC_W = 11;
    localparam int FILE_AW = 5;
    localparam int INSTR_W = 17;

    // ==========================================================
    // Register word indices (byte address = index * 4)
    // ==========================================================
    localparam logic [5:0] IDX_INSTR = 6'h00;
    localparam logic [5:0] IDX_ACC = 6'h01;
    localparam logic [5:0] IDX_STATUS = 6'h02;
    localparam logic [5:0] IDX_PRESCFG = 6'h03;
    localparam logic [5:0] IDX_PC = 6'h04;
    localparam logic [5:0] IDX_STACK = 6'h05;
    localparam logic [5:0] IDX_WDT = 6'h06;
    localparam logic [5:0] IDX_CTRL = 6'h07;
    localparam int FILE_SEL_BIT = 7;

    // ==========================================================
    // Status and control bit positions
    // ==========================================================
    localparam int ST_C_BIT = 0;
    localparam int ST_DC_BIT = 1;
    localparam int ST_Z_BIT = 2;
    localparam int ST_PWRDN_BIT = 3;
    localparam int ST_TO_BIT = 4;
    localparam int ST_WAKE_BIT = 5;
    localparam int ST_BUSY_BIT = 8;
    localparam int ST_SLEEP_BIT = 9;
    localparam int CTRL_WAKE_BIT = 0;

    // ==========================================================
    // Reset values
    // ==========================================================
    localparam logic [7:0] ACC_RST = 8'h00;
    localparam logic [7:0] PRESCFG_RST = 8'h00;
    localparam logic [10:0] PC_RST = 11'h000;

    // ==========================================================
    // Types
    // ==========================================================
    typedef enum logic [2:0] {
        OP_NOP,
        OP_LOAD_PRESCALER,
        OP_RETURN_LIT,
        OP_SLEEP,
        OP_ROT_LEFT,
        OP_ROT_RIGHT,
        OP_SUB_ACC
    } bix_op_t;

    typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_FLUSH, ST_SLEEP} bix_fsm_t;

    // Instruction word: op in bits 2:0, dest 3, file 8:4, literal 16:9
    typedef struct packed {
        logic [7:0] lit;
        logic [4:0] faddr;
        logic dest;
        bix_op_t op;
    } bix_instr_t;

    typedef struct packed {
        bix_op_t op;
        logic [7:0] fval;
        logic [7:0] acc;
        logic c;
    } bix_alu_in_t;

    typedef struct packed {
        logic [7:0] res;
        logic c;
        logic dc;
        logic z;
    } bix_alu_out_t;

    typedef struct packed {
        logic [7:0] presc;
        logic [7:0] count;
    } bix_wdt_t;

endpackage

// ==== bix_alu.sv ====
/*
 * Combinational datapath for rotate-through-carry and subtract.
 * Assumes the caller selects the destination and the flags to keep.
 */
`timescale 1ns/1ps
module bix_alu (
    input wire bix_pkg::bix_alu_in_t alu_i, // Operands and opcode
    output bix_pkg::bix_alu_out_t alu_o     // Result and flags
);
    import bix_pkg::*;

    logic [8:0] diff;
    logic [4:0] ndiff;

    // ==========================================================
    // Result and flag selection
    // ==========================================================
    always_comb begin
        diff = {1'b0, alu_i.fval} + {1'b0, ~alu_i.acc} + 9'h001;
        ndiff = {1'b0, alu_i.fval[3:0]} + {1'b0, ~alu_i.acc[3:0]} + 5'h01;
        alu_o = '{res: alu_i.fval, c: alu_i.c, dc: 1'b0, z: 1'b0};
        unique case (alu_i.op)
            OP_ROT_LEFT: begin
                alu_o.res = {alu_i.fval[6:0], alu_i.c};
                alu_o.c = alu_i.fval[7];
            end
            OP_ROT_RIGHT: begin
                alu_o.res = {alu_i.c, alu_i.fval[7:1]};
                alu_o.c = alu_i.fval[0];
            end
            OP_SUB_ACC: begin
                alu_o.res = diff[7:0];
                alu_o.c = diff[8];
                alu_o.dc = ndiff[4];
                alu_o.z = (diff[7:0] == 8'h00);
            end
            default: begin
                alu_o.res = alu_i.fval;
            end
        endcase
    end
endmodule

// ==== bix_wdt.sv ====
/*
 * Watchdog counter with its prescaler; both free running.
 * Assumes the clear input is a one-cycle pulse from the core.
 */
`timescale 1ns/1ps
module bix_wdt (
    input wire logic clk_i,              // Core clock
    input wire logic rst_n_i,            // Synchronous reset, active low
    input wire logic clear_i,            // Clear counter and prescaler
    output bix_pkg::bix_wdt_t wdt_o      // Current prescaler and count
);
    import bix_pkg::*;

    bix_wdt_t st;
    bix_wdt_t next_st;

    // ==========================================================
    // Count; clear has priority over the tick
    // ==========================================================
    always_comb begin
        next_st = st;
        next_st.presc = st.presc + 8'h01;
        if (st.presc == 8'hFF) begin
            next_st.count = st.count + 8'h01;
        end
        if (clear_i) begin
            next_st = '0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign wdt_o = st;
endmodule

// ==== bix_core.sv ====
/*
 * Execution block for six instructions of a small 8-bit accumulator core,
 * with its accumulator, flags, 32 file registers, prescaler configuration
 * and program counter, all reachable over a classic Wishbone slave.
 * Assumes software feeds instructions through the instruction register
 * and supplies the return address in the stack-top register.
 */
// Local design decisions: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/1ps
module bix_core (
    input wire logic clk_i,                  // Core clock, 250 MHz
    input wire logic rst_n_i,                // Synchronous reset, active low
    input wire logic wb_cyc_i,               // Wishbone cycle
    input wire logic wb_stb_i,               // Wishbone strobe
    input wire logic wb_we_i,                // Wishbone write enable
    input wire logic [7:0] wb_adr_i,         // Wishbone byte address
    input wire logic [31:0] wb_dat_i,        // Wishbone write data
    input wire logic [3:0] wb_sel_i,         // Wishbone byte lanes
    output logic [31:0] wb_dat_o,            // Wishbone read data
    output logic wb_ack_o,                   // Wishbone acknowledge
    output logic [10:0] pc_o,                // Program counter
    output logic [7:0] prescfg_o,            // Prescaler configuration
    output logic discard_o,                  // Prefetched word discarded
    output logic sleep_o,                    // Core in sleep mode
    output logic osc_stop_o                  // Oscillator stop request
);
    import bix_pkg::*;

    // ==========================================================
    // State
    // ==========================================================
    typedef struct packed {
        bix_fsm_t fsm;
        bix_instr_t instr;
        logic [7:0] acc;
        logic [7:0] prescfg;
        logic [10:0] pc;
        logic [10:0] stack_top;
        logic c;
        logic dc;
        logic z;
        logic powerdown_flag_n;
        logic to_n;
        logic wake;
        logic [31:0][7:0] file;
        logic ack;
        logic [31:0] rdata;
    } bix_core_st_t;

    bix_core_st_t st;
    bix_core_st_t next_st;
    bix_alu_in_t alu_in;
    bix_alu_out_t alu_out;
    bix_wdt_t wdt;
    logic wdt_clr;
    logic bus_wr;
    logic [31:0] wmask;
    logic [31:0] wval;
    logic [5:0] idx;
    logic is_file;
    logic [7:0] cur_f;

    // Byte-lane merge of a write into an old register word
    function automatic logic [31:0] lane_merge(input logic [31:0] old,
                                               input logic [31:0] dat,
                                               input logic [3:0] sel);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                res[i*8 +: 8] = dat[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // Status word as software sees it
    function automatic logic [31:0] status_word(input bix_core_st_t s);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[ST_C_BIT] = s.c;
        w[ST_DC_BIT] = s.dc;
        w[ST_Z_BIT] = s.z;
        w[ST_PWRDN_BIT] = s.powerdown_flag_n;
        w[ST_TO_BIT] = s.to_n;
        w[ST_WAKE_BIT] = s.wake;
        w[ST_BUSY_BIT] = (s.fsm == ST_EXEC) || (s.fsm == ST_FLUSH);
        w[ST_SLEEP_BIT] = (s.fsm == ST_SLEEP);
        return w;
    endfunction

    // ==========================================================
    // Datapath and watchdog
    // ==========================================================
    assign cur_f = st.file[st.instr.faddr];
    assign alu_in = '{op: st.instr.op, fval: cur_f, acc: st.acc, c: st.c};

    bix_alu u_alu (
        .alu_i(alu_in),
        .alu_o(alu_out)
    );

    bix_wdt u_wdt (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .clear_i(wdt_clr),
        .wdt_o(wdt)
    );

    // Bus decode shared by reads and writes
    assign idx = wb_adr_i[7:2];
    assign is_file = wb_adr_i[FILE_SEL_BIT];
    // Write lands on the edge where the master sees ack, not one earlier
    assign bus_wr = wb_cyc_i && wb_stb_i && wb_we_i && st.ack;
    assign wmask = lane_merge(32'h0000_0000, 32'hFFFF_FFFF, wb_sel_i);

    // ==========================================================
    // Next-state logic
    // ==========================================================
    always_comb begin
        next_st = st;
        wdt_clr = 1'b0;
        wval = 32'h0000_0000;
        // Ack one cycle after the request, dropped the cycle after
        next_st.ack = wb_cyc_i && wb_stb_i && !st.ack;
        if (next_st.ack && !wb_we_i) begin
            if (is_file) begin
                next_st.rdata = {24'h000000, st.file[wb_adr_i[6:2]]};
            end else begin
                unique case (idx)
                    IDX_INSTR: next_st.rdata = {15'h0000, st.instr};
                    IDX_ACC: next_st.rdata = {24'h000000, st.acc};
                    IDX_STATUS: next_st.rdata = status_word(st);
                    IDX_PRESCFG: next_st.rdata = {24'h000000, st.prescfg};
                    IDX_PC: next_st.rdata = {21'h000000, st.pc};
                    IDX_STACK: next_st.rdata = {21'h000000, st.stack_top};
                    IDX_WDT: next_st.rdata = {16'h0000, wdt};
                    default: next_st.rdata = 32'h0000_0000;
                endcase
            end
        end
        // Architectural writes only while no instruction is in flight,
        // so an executing instruction never races a software write
        if (bus_wr && (st.fsm == ST_IDLE || st.fsm == ST_SLEEP)) begin
            if (is_file) begin
                wval = lane_merge({24'h000000, st.file[wb_adr_i[6:2]]},
                                  wb_dat_i, wb_sel_i);
                next_st.file[wb_adr_i[6:2]] = wval[7:0];
            end else begin
                unique case (idx)
                    IDX_ACC: begin
                        wval = lane_merge({24'h000000, st.acc}, wb_dat_i, wb_sel_i);
                        next_st.acc = wval[7:0];
                    end
                    IDX_STATUS: begin
                        wval = lane_merge(status_word(st), wb_dat_i, wb_sel_i);
                        next_st.c = wval[ST_C_BIT];
                        next_st.dc = wval[ST_DC_BIT];
                        next_st.z = wval[ST_Z_BIT];
                        next_st.wake = wval[ST_WAKE_BIT];
                    end
                    IDX_STACK: begin
                        wval = lane_merge({21'h000000, st.stack_top}, wb_dat_i, wb_sel_i);
                        next_st.stack_top = wval[10:0];
                    end
                    default: wval = 32'h0000_0000;
                endcase
            end
        end
        // Instruction sequencer
        unique case (st.fsm)
            ST_IDLE: begin
                if (bus_wr && !is_file && idx == IDX_INSTR && wmask[0]) begin
                    next_st.instr = bix_instr_t'(wb_dat_i[INSTR_W-1:0]);
                    next_st.fsm = ST_EXEC;
                end
            end
            ST_EXEC: begin
                next_st.fsm = ST_IDLE;
                next_st.pc = st.pc + 11'h001;
                unique case (st.instr.op)
                    OP_LOAD_PRESCALER: next_st.prescfg = st.acc;
                    OP_RETURN_LIT: begin
                        next_st.acc = st.instr.lit;
                        next_st.pc = st.stack_top;
                        next_st.fsm = ST_FLUSH;
                    end
                    OP_SLEEP: begin
                        wdt_clr = 1'b1;
                        next_st.to_n = 1'b1;
                        next_st.powerdown_flag_n = 1'b0;
                        next_st.fsm = ST_SLEEP;
                    end
                    OP_ROT_LEFT, OP_ROT_RIGHT, OP_SUB_ACC: begin
                        if (st.instr.dest) begin
                            next_st.file[st.instr.faddr] = alu_out.res;
                        end else begin
                            next_st.acc = alu_out.res;
                        end
                        next_st.c = alu_out.c;
                        // subtract also updates dc and z
                        if (st.instr.op == OP_SUB_ACC) begin
                            next_st.dc = alu_out.dc;
                            next_st.z = alu_out.z;
                        end
                    end
                    default: next_st.fsm = ST_IDLE;
                endcase
            end
            ST_FLUSH: next_st.fsm = ST_IDLE;
            ST_SLEEP: begin
                // Wake only by software; no wake sources modelled here
                if (bus_wr && !is_file && idx == IDX_CTRL && wmask[0]
                        && wb_dat_i[CTRL_WAKE_BIT]) begin
                    next_st.fsm = ST_IDLE;
                end
            end
        endcase
    end

    // ==========================================================
    // State register
    // ==========================================================
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            st <= '0;
            st.fsm <= ST_IDLE;
            st.acc <= ACC_RST;
            st.prescfg <= PRESCFG_RST;
            st.pc <= PC_RST;
            st.powerdown_flag_n <= 1'b1;
            st.to_n <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // ==========================================================
    // Outputs
    // ==========================================================
    assign wb_ack_o = st.ack;
    assign wb_dat_o = st.rdata;
    assign pc_o = st.pc;
    assign prescfg_o = st.prescfg;
    assign discard_o = (st.fsm == ST_FLUSH);
    assign sleep_o = (st.fsm == ST_SLEEP);
    assign osc_stop_o = (st.fsm == ST_SLEEP);

    // ==========================================================
    // Assertions
    // ==========================================================
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);

    logic ex;
    assign ex = (st.fsm == ST_EXEC);

    property p_prescaler_load;
        ex && st.instr.op == OP_LOAD_PRESCALER |=> st.prescfg == $past(st.acc)
            && $stable({st.c, st.dc, st.z, st.powerdown_flag_n, st.to_n});
    endproperty
    a_prescaler_load: assert property (p_prescaler_load) else $error("prescaler load wrong");

    property p_ret_literal;
        ex && st.instr.op == OP_RETURN_LIT |=> st.acc == $past(st.instr.lit)
            && $stable({st.c, st.dc, st.z, st.powerdown_flag_n, st.to_n, st.wake});
    endproperty
    a_ret_literal: assert property (p_ret_literal) else $error("return literal wrong");

    property p_ret_pc;
        ex && st.instr.op == OP_RETURN_LIT |=> pc_o == $past(st.stack_top);
    endproperty
    a_ret_pc: assert property (p_ret_pc) else $error("return pc wrong");

    property p_ret_two_cycles;
        ex && st.instr.op == OP_RETURN_LIT |=> discard_o ##1 (!discard_o && st.fsm == ST_IDLE);
    endproperty
    a_ret_two_cycles: assert property (p_ret_two_cycles) else $error("return not two cycles");

    property p_sleep_wdt;
        ex && st.instr.op == OP_SLEEP |=> wdt.count == 8'h00 && wdt.presc == 8'h00;
    endproperty
    a_sleep_wdt: assert property (p_sleep_wdt) else $error("watchdog not cleared");

    property p_sleep_flags;
        ex && st.instr.op == OP_SLEEP |=> st.to_n && !st.powerdown_flag_n && $stable(st.wake);
    endproperty
    a_sleep_flags: assert property (p_sleep_flags) else $error("sleep flags wrong");

    property p_sleep_enter;
        ex && st.instr.op == OP_SLEEP |=> (sleep_o && osc_stop_o) ##1 (osc_stop_o == sleep_o);
    endproperty
    a_sleep_enter: assert property (p_sleep_enter) else $error("sleep not entered");

    property p_rot_left;
        ex && st.instr.op == OP_ROT_LEFT && st.instr.dest |=>
            st.file[$past(st.instr.faddr)] == {$past(cur_f[6:0]), $past(st.c)}
            && st.c == $past(cur_f[7]) && $stable({st.dc, st.z});
    endproperty
    a_rot_left: assert property (p_rot_left) else $error("rotate left wrong");

    property p_rot_right;
        ex && st.instr.op == OP_ROT_RIGHT && !st.instr.dest |=>
            st.acc == {$past(st.c), $past(cur_f[7:1])}
            && st.c == $past(cur_f[0]) && $stable({st.dc, st.z});
    endproperty
    a_rot_right: assert property (p_rot_right) else $error("rotate right wrong");

    property p_dest_acc;
        ex && st.instr.op inside {OP_ROT_LEFT, OP_ROT_RIGHT, OP_SUB_ACC}
            && !st.instr.dest |=> $stable(st.file);
    endproperty
    a_dest_acc: assert property (p_dest_acc) else $error("file written for acc dest");

    property p_sub_value;
        ex && st.instr.op == OP_SUB_ACC && st.instr.dest |=>
            st.file[$past(st.instr.faddr)] == 8'($past(cur_f) - $past(st.acc))
            && $stable(st.acc);
    endproperty
    a_sub_value: assert property (p_sub_value) else $error("subtract result wrong");

    property p_sub_flags;
        ex && st.instr.op == OP_SUB_ACC |=> st.c == ($past(cur_f) >= $past(st.acc))
            && st.dc == ($past(cur_f[3:0]) >= $past(st.acc[3:0]))
            && st.z == ($past(cur_f) == $past(st.acc));
    endproperty
    a_sub_flags: assert property (p_sub_flags) else $error("subtract flags wrong");

    c_ret: cover property (ex && st.instr.op == OP_RETURN_LIT ##2 st.fsm == ST_IDLE);
    c_sleep_wake: cover property (sleep_o ##[1:20] !sleep_o);
    c_sub_zero: cover property (ex && st.instr.op == OP_SUB_ACC ##1 st.z);
    c_rot_file: cover property (ex && st.instr.op == OP_ROT_LEFT && st.instr.dest);
endmodule

// ==== tb_top.sv ====
/* Self-checking bench for bix_core, driving its Wishbone port directly.
   Assumes the bix_pkg register map and a 250 MHz clock. */
`timescale 1ns/1ps
module tb_top;
    import bix_pkg::*;
    // ==========
    // Signals
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [31:0] wb_dat_i = 32'h0;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o, discard_o, sleep_o, osc_stop_o;
    logic [10:0] pc_o;
    logic [7:0] prescfg_o;
    int mismatches = 0;
    int tests_run = 0;
    int cycles = 0;
    logic [31:0] r;

    bix_core uut (.clk_i(clk_i), .rst_n_i(rst_n_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .pc_o(pc_o), .prescfg_o(prescfg_o),
        .discard_o(discard_o), .sleep_o(sleep_o), .osc_stop_o(osc_stop_o));

    // Half period 2 ns
    always #2 clk_i = ~clk_i;

    // Hang guard, far above the expected run length
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 6000) begin
            mismatches++;
            tally_and_finish();
        end
    end

    // ==========
    // Shared tasks
    task automatic tally_and_finish();
        $display("tests_run=%0d mismatches=%0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One classic cycle; request held until ack is sampled high
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= dat;
        wb_sel_i <= 4'hF;
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        r = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask

    function automatic logic [31:0] ins(bix_op_t op, logic d, logic [4:0] f, logic [7:0] k);
        return {15'h0000, k, f, d, op};
    endfunction

    // Issue, count discard cycles, then poll until idle or asleep
    task automatic ex(input logic [31:0] i, input int nd);
        int n;
        n = 0;
        wb(1'b1, 8'h00, i);
        repeat (6) begin
            @(posedge clk_i);
            #1;
            if (discard_o === 1'b1) n++;
        end
        chk(n, nd);
        do wb(1'b0, 8'h08, 32'h0); while (r[8] === 1'b1 && sleep_o !== 1'b1);
    endtask

    // ==========
    // Scenarios
    task automatic t_presc();
        wb(1'b1, 8'h04, 32'h5A);
        wb(1'b1, 8'h08, 32'h27);
        ex(ins(OP_LOAD_PRESCALER, 1'b0, 5'h00, 8'h00), 0);
        chk(prescfg_o, 32'h5A);
        wb(1'b0, 8'h08, 32'h0);
        chk(r[5:0], 32'h3F);
        wb(1'b1, 8'h0C, 32'hFF);
        chk(prescfg_o, 32'h5A);
        wb(1'b0, 8'h20, 32'h0);
        chk(r, 32'h0);
        chk(pc_o, 32'h1);
        $display("test load_prescaler done");
    endtask

    task automatic t_ret();
        wb(1'b1, 8'h14, 32'h7FF);
        wb(1'b1, 8'h08, 32'h0);
        ex(ins(OP_RETURN_LIT, 1'b0, 5'h00, 8'hFF), 1);
        wb(1'b0, 8'h04, 32'h0);
        chk(r, 32'hFF);
        chk(pc_o, 32'h7FF);
        wb(1'b0, 8'h08, 32'h0);
        chk(r[5:0], 32'h18);
        $display("test return done");
    endtask

    // Flags preset to 1 so only a carry change can show
    task automatic t_rot();
        wb(1'b1, 8'h94, 32'h81);
        wb(1'b1, 8'h98, 32'h02);
        wb(1'b1, 8'h08, 32'h07);
        ex(ins(OP_ROT_LEFT, 1'b1, 5'h05, 8'h00), 0);
        wb(1'b0, 8'h94, 32'h0);
        chk(r, 32'h03);
        wb(1'b0, 8'h08, 32'h0);
        chk(r[2:0], 32'h7);
        ex(ins(OP_ROT_RIGHT, 1'b0, 5'h06, 8'h00), 0);
        wb(1'b0, 8'h04, 32'h0);
        chk(r, 32'h81);
        wb(1'b0, 8'h98, 32'h0);
        chk(r, 32'h02);
        wb(1'b0, 8'h08, 32'h0);
        chk(r[2:0], 32'h6);
        $display("test rotate done");
    endtask

    // Digit-borrow, equal, wrap and no-borrow cases on the last file register
    task automatic t_sub();
        logic [7:0] fv[4] = '{8'h10, 8'h05, 8'h00, 8'h80};
        logic [7:0] wv[4] = '{8'h01, 8'h05, 8'h01, 8'h10};
        logic [8:0] df;
        logic [2:0] fl;
        for (int i = 0; i < 4; i++) begin
            wb(1'b1, 8'hFC, {24'h0, fv[i]});
            wb(1'b1, 8'h04, {24'h0, wv[i]});
            ex(ins(OP_SUB_ACC, i[0], 5'h1F, 8'h00), 0);
            df = {1'b0, fv[i]} - {1'b0, wv[i]};
            fl = {df[7:0] == 8'h00, fv[i][3:0] >= wv[i][3:0], ~df[8]};
            wb(1'b0, 8'h08, 32'h0);
            chk(r[2:0], fl);
            wb(1'b0, 8'hFC, 32'h0);
            chk(r, i[0] ? df[7:0] : fv[i]);
            wb(1'b0, 8'h04, 32'h0);
            chk(r, i[0] ? wv[i] : df[7:0]);
        end
        $display("test subtract done");
    endtask

    // Let the watchdog advance first so the clear is visible
    task automatic t_sleep();
        repeat (600) @(posedge clk_i);
        wb(1'b0, 8'h18, 32'h0);
        chk(r[7:0] != 8'h00, 32'h1);
        wb(1'b1, 8'h08, 32'h20);
        ex(ins(OP_SLEEP, 1'b0, 5'h00, 8'h00), 0);
        chk(sleep_o, 32'h1);
        chk(osc_stop_o, 32'h1);
        wb(1'b0, 8'h18, 32'h0);
        chk(r[7:0], 32'h0);
        chk(r[15:8] < 8'h20, 32'h1);
        wb(1'b0, 8'h08, 32'h0);
        chk(r[5:3], 32'h6);
        wb(1'b1, 8'h1C, 32'h1);
        #1;
        chk(sleep_o, 32'h0);
        $display("test sleep done");
    endtask

    // Main sequence
    initial begin
        repeat (5) @(posedge clk_i);
        rst_n_i <= 1'b1;
        @(posedge clk_i);
        wb(1'b0, 8'h08, 32'h0);
        chk(r[5:0], 32'h18);
        t_presc();
        t_ret();
        t_rot();
        t_sub();
        t_sleep();
        tally_and_finish();
    end
endmodule
